// *** rtl/sdci_pkg.sv ***
package sdci_pkg;

  // ---------------------------------------------------------------
  // Command requests
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SDCI_CMD_NONE  = 4'h0,
    SDCI_CMD_NOP   = 4'h1,
    SDCI_CMD_ACT   = 4'h2,
    SDCI_CMD_READ  = 4'h3,
    SDCI_CMD_WRITE = 4'h4,
    SDCI_CMD_BTERM = 4'h5,
    SDCI_CMD_PRE   = 4'h6,
    SDCI_CMD_REF   = 4'h7,
    SDCI_CMD_LMODE = 4'h8
  } sdci_cmd_t;

  // Port sizes
  localparam logic [1:0] SDCI_PS_32 = 2'h0;
  localparam logic [1:0] SDCI_PS_16 = 2'h1;
  localparam logic [1:0] SDCI_PS_8  = 2'h2;

  // ---------------------------------------------------------------
  // Strobe codes {cs, row, col, we}
  // ---------------------------------------------------------------
  localparam logic [3:0] SDCI_CODE_INH   = 4'hF;
  localparam logic [3:0] SDCI_CODE_NOP   = 4'h7;
  localparam logic [3:0] SDCI_CODE_ACT   = 4'h3;
  localparam logic [3:0] SDCI_CODE_READ  = 4'h5;
  localparam logic [3:0] SDCI_CODE_WRITE = 4'h4;
  localparam logic [3:0] SDCI_CODE_BTERM = 4'h6;
  localparam logic [3:0] SDCI_CODE_PRE   = 4'h2;
  localparam logic [3:0] SDCI_CODE_REF   = 4'h1;
  localparam logic [3:0] SDCI_CODE_LMODE = 4'h0;

  // ---------------------------------------------------------------
  // Address bit positions of the internal address
  // ---------------------------------------------------------------
  localparam int SDCI_COL32_LSB  = 2;
  localparam int SDCI_COL16_LSB  = 1;
  localparam int SDCI_COL_W      = 10;
  localparam int SDCI_BA16M_32   = 21;
  localparam int SDCI_BA64M_32   = 22;
  localparam int SDCI_A11_32     = 13;
  localparam int SDCI_BA16M_16   = 20;
  localparam int SDCI_BA64M_16   = 21;
  localparam int SDCI_A11_16     = 12;
  localparam int SDCI_AP_PS32    = 20;
  localparam int SDCI_AP_PS16    = 19;
  localparam int SDCI_AP_PS8     = 18;

  // ---------------------------------------------------------------
  // Mode register op-code fields
  // ---------------------------------------------------------------
  localparam logic [2:0] SDCI_MR_WBM   = 3'h1;
  localparam logic [1:0] SDCI_MR_OPM   = 2'h0;
  localparam logic       SDCI_MR_BT    = 1'b0;
  localparam logic [2:0] SDCI_MR_BL    = 3'h7;

endpackage : sdci_pkg

// *** rtl/sdci_cmd_pins.sv ***
`timescale 1ns/1ns
// Operation
// - Commands valid only with chip select low; SDRAM samples on rising clock.
// - Chip select, row, column, write strobes and A10/AP line drive SDRAM.
// - x32: A2..A11 to SDRAM A0..A9; upper masks BE3/BE2, lower BE1/BE0.
// - x32 bank: A21 for 16M; A22/A23 for 64M banks, A13 as A11.
// - x16: A1..A10 to SDRAM A0..A9; BE3/BE2 masks, BE1/BE0 unused.
// - x16 bank: A20 for 16M; A21/A22 for 64M banks, A12 as A11.
// - ACTIVE drives A10/AP with A20, A19 or A18 by port size.
// - READ and WRITE drive A10/AP low, never auto precharge.
// - PRECHARGE drives A10/AP high, closing all banks.
// - Inhibit, NOP, ACTIVE, READ, WRITE codes on the four strobes.
// - Burst terminate, precharge, refresh, load mode codes; load mode AP low.
// - First access after chip select valid set issues load mode first.
module sdci_cmd_pins
  import sdci_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Configuration
  input  wire logic              cs_valid,
  input  wire logic              array_x16,
  input  wire logic              part_64m,
  input  wire logic [1:0]        port_size,
  input  wire logic [1:0]        cas_latency_field,
  // Command request
  input  wire sdci_pkg::sdci_cmd_t cmd_req,
  input  wire logic [23:0]       addr_in,
  input  wire logic [3:0]        byte_en_n,
  output logic                   mode_load_busy,
  // SDRAM pins
  output logic                   chip_select_out_n,
  output logic                   row_strobe_out_n,
  output logic                   column_strobe_out_n,
  output logic                   write_strobe_out_n,
  output logic                   precharge_flag_out_n,
  output logic [11:0]            sdram_addr_out,
  output logic [1:0]             sdram_bank_out,
  output logic                   byte_lane3_enable_n,
  output logic                   byte_lane2_enable_n,
  output logic                   byte_lane1_enable_n,
  output logic                   byte_lane0_enable_n,
  output logic                   sdram_cke_out
);
  import sdci_pkg::*;

  // ---------------------------------------------------------------
  // Mode load tracking
  // ---------------------------------------------------------------
  logic       valid_seen_reg;
  logic       valid_seen_next;
  logic       need_mode_reg;
  logic       need_mode_next;
  logic       issue_mode;
  logic       mode_pending;

  // Issue the load mode in place of the first real access; the caller
  // sees busy for that cycle and repeats its request afterwards.
  // The cycle that sees the valid bit rise already counts as pending,
  // so a request in that same cycle cannot slip out ahead of it.
  assign mode_pending = cs_valid && (need_mode_reg || !valid_seen_reg);
  assign issue_mode = mode_pending && (cmd_req != SDCI_CMD_NONE);
  assign mode_load_busy = issue_mode;

  always_comb begin
    valid_seen_next = cs_valid;
    // Dropping the valid bit forgets the pending load; raising re-arms
    need_mode_next  = mode_pending && !issue_mode;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      valid_seen_reg <= 1'b0;
      need_mode_reg  <= 1'b0;
    end else begin
      valid_seen_reg <= valid_seen_next;
      need_mode_reg  <= need_mode_next;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [3:0]  code_next;
  logic        ap_next;
  logic [11:0] addr_next;
  logic [1:0]  bank_next;
  logic [3:0]  mask_next;
  logic        ap_row;
  logic [9:0]  col;
  logic [11:0] mode_op;

  // Latency sum kept 3 bits wide so a field of 3 gives 4, not 0
  assign mode_op = {SDCI_MR_WBM, SDCI_MR_OPM,
                    3'({1'b0, cas_latency_field} + 3'h1),
                    SDCI_MR_BT, SDCI_MR_BL};

  always_comb begin
    case (port_size)
      SDCI_PS_32: ap_row = addr_in[SDCI_AP_PS32];
      SDCI_PS_16: ap_row = addr_in[SDCI_AP_PS16];
      default:    ap_row = addr_in[SDCI_AP_PS8];
    endcase
  end

  always_comb begin
    // Column and bank routing by array width and part size
    if (array_x16) begin
      col = addr_in[SDCI_COL16_LSB +: SDCI_COL_W];
      addr_next = {addr_in[SDCI_A11_16] & part_64m, 1'b0, col};
      bank_next = part_64m ? addr_in[SDCI_BA64M_16 +: 2]
                           : {1'b0, addr_in[SDCI_BA16M_16]};
      mask_next = {byte_en_n[3:2], 2'h3};
    end else begin
      col = addr_in[SDCI_COL32_LSB +: SDCI_COL_W];
      addr_next = {addr_in[SDCI_A11_32] & part_64m, 1'b0, col};
      bank_next = part_64m ? addr_in[SDCI_BA64M_32 +: 2]
                           : {1'b0, addr_in[SDCI_BA16M_32]};
      mask_next = byte_en_n;
    end
    ap_next = 1'b0;
    if (!cs_valid) begin
      code_next = SDCI_CODE_INH;
    end else if (issue_mode) begin
      code_next = SDCI_CODE_LMODE;
      addr_next = mode_op;
      bank_next = 2'h0;
      ap_next   = 1'b0;
    end else begin
      case (cmd_req)
        SDCI_CMD_NOP:   code_next = SDCI_CODE_NOP;
        SDCI_CMD_ACT: begin
          code_next = SDCI_CODE_ACT;
          ap_next   = ap_row;
        end
        SDCI_CMD_READ:  code_next = SDCI_CODE_READ;
        SDCI_CMD_WRITE: code_next = SDCI_CODE_WRITE;
        SDCI_CMD_BTERM: code_next = SDCI_CODE_BTERM;
        SDCI_CMD_PRE: begin
          code_next = SDCI_CODE_PRE;
          ap_next   = 1'b1;
        end
        SDCI_CMD_REF:   code_next = SDCI_CODE_REF;
        SDCI_CMD_LMODE: begin
          code_next = SDCI_CODE_LMODE;
          addr_next = mode_op;
          bank_next = 2'h0;
        end
        default:        code_next = SDCI_CODE_INH;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  logic [3:0]  code_reg;
  logic        ap_reg;
  logic [11:0] addr_reg;
  logic [1:0]  bank_reg;
  logic [3:0]  mask_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= SDCI_CODE_INH;
      ap_reg   <= 1'b0;
      addr_reg <= 12'h000;
      bank_reg <= 2'h0;
      mask_reg <= 4'hF;
    end else begin
      code_reg <= code_next;
      ap_reg   <= ap_next;
      addr_reg <= addr_next;
      bank_reg <= bank_next;
      mask_reg <= mask_next;
    end
  end

  // Strobes launched from flops so the SDRAM sees them stable at its edge
  assign chip_select_out_n    = code_reg[3];
  assign row_strobe_out_n     = code_reg[2];
  assign column_strobe_out_n  = code_reg[1];
  assign write_strobe_out_n   = code_reg[0];
  assign precharge_flag_out_n = ap_reg;
  assign sdram_addr_out       = addr_reg;
  assign sdram_bank_out       = bank_reg;
  assign byte_lane3_enable_n  = mask_reg[3];
  assign byte_lane2_enable_n  = mask_reg[2];
  assign byte_lane1_enable_n  = mask_reg[1];
  assign byte_lane0_enable_n  = mask_reg[0];
  assign sdram_cke_out        = 1'b1;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic [3:0] pins_code;
  logic       plain_req;

  assign pins_code = {chip_select_out_n, row_strobe_out_n,
                      column_strobe_out_n, write_strobe_out_n};
  // Requests that go out as themselves, not swapped for a load mode
  assign plain_req = cs_valid && !issue_mode;

  // Valid bit raised while the caller is idle
  sequence s_arm_idle;
    cs_valid && !valid_seen_reg && cmd_req == SDCI_CMD_NONE;
  endsequence

  // First request on the cycle after an idle arming
  sequence s_first_req;
    s_arm_idle ##1 (cs_valid && cmd_req != SDCI_CMD_NONE);
  endsequence

  idle_inhibit_a: assert property (
    (!cs_valid || cmd_req == SDCI_CMD_NONE) |=> chip_select_out_n)
    else $error("chip select not high while idle");
  read_ap_low_a: assert property (
    (cs_valid && !issue_mode && cmd_req inside {SDCI_CMD_READ,
      SDCI_CMD_WRITE}) |=> !precharge_flag_out_n && !chip_select_out_n
      && column_strobe_out_n == 1'b0)
    else $error("read or write with AP not low");
  pre_ap_high_a: assert property (
    (cs_valid && !issue_mode && cmd_req == SDCI_CMD_PRE)
      |=> precharge_flag_out_n && !row_strobe_out_n && !write_strobe_out_n)
    else $error("precharge without all banks");
  act_row_bit_a: assert property (
    (cs_valid && !issue_mode && cmd_req == SDCI_CMD_ACT)
      |=> precharge_flag_out_n == $past(ap_row) && !row_strobe_out_n)
    else $error("active row bit wrong");
  refresh_code_a: assert property (
    (cs_valid && !issue_mode && cmd_req == SDCI_CMD_REF)
      |=> {chip_select_out_n, row_strobe_out_n, column_strobe_out_n,
           write_strobe_out_n} == SDCI_CODE_REF)
    else $error("refresh code wrong");
  mode_first_a: assert property (
    s_first_req |=> pins_code == SDCI_CODE_LMODE
      && sdram_addr_out[11:9] == SDCI_MR_WBM && !precharge_flag_out_n)
    else $error("first access did not load mode");
  mode_same_a: assert property (
    (cs_valid && !valid_seen_reg && cmd_req != SDCI_CMD_NONE)
      |-> mode_load_busy ##1 (pins_code == SDCI_CODE_LMODE))
    else $error("request on valid edge skipped load mode");
  mode_fields_a: assert property (
    issue_mode |=> sdram_addr_out[8:0] == {SDCI_MR_OPM,
      {1'b0, $past(cas_latency_field)} + 3'h1, SDCI_MR_BT, SDCI_MR_BL})
    else $error("mode op-code fields wrong");
  x16_mask_a: assert property (
    array_x16 |=> byte_lane1_enable_n && byte_lane0_enable_n)
    else $error("unused x16 lanes enabled");
  x32_col_a: assert property (
    (cs_valid && !array_x16 && !issue_mode && cmd_req == SDCI_CMD_READ)
      |=> sdram_addr_out[9:0] == $past(addr_in[11:2]))
    else $error("x32 column routing wrong");
  cke_high_a: assert property (sdram_cke_out)
    else $error("clock enable dropped");
  nop_code_a: assert property (
    (plain_req && cmd_req == SDCI_CMD_NOP)
      |=> pins_code == SDCI_CODE_NOP)
    else $error("nop code wrong");
  act_code_a: assert property (
    (plain_req && cmd_req == SDCI_CMD_ACT)
      |=> pins_code == SDCI_CODE_ACT)
    else $error("active code wrong");
  read_code_a: assert property (
    (plain_req && cmd_req == SDCI_CMD_READ)
      |=> pins_code == SDCI_CODE_READ)
    else $error("read code wrong");
  write_code_a: assert property (
    (plain_req && cmd_req == SDCI_CMD_WRITE)
      |=> pins_code == SDCI_CODE_WRITE)
    else $error("write code wrong");
  bterm_code_a: assert property (
    (plain_req && cmd_req == SDCI_CMD_BTERM)
      |=> pins_code == SDCI_CODE_BTERM)
    else $error("burst terminate code wrong");
  pre_code_a: assert property (
    (plain_req && cmd_req == SDCI_CMD_PRE)
      |=> pins_code == SDCI_CODE_PRE)
    else $error("precharge code wrong");
  lmode_code_a: assert property (
    (plain_req && cmd_req == SDCI_CMD_LMODE)
      |=> pins_code == SDCI_CODE_LMODE && !precharge_flag_out_n)
    else $error("load mode code wrong");
  cs_active_a: assert property (
    (cs_valid && cmd_req != SDCI_CMD_NONE)
      |=> !chip_select_out_n)
    else $error("request without chip select");
  x32_lanes_a: assert property (
    !array_x16 |=> {byte_lane3_enable_n, byte_lane2_enable_n,
      byte_lane1_enable_n, byte_lane0_enable_n} == $past(byte_en_n))
    else $error("x32 lane masks wrong");
  x16_upper_a: assert property (
    array_x16 |=> {byte_lane3_enable_n, byte_lane2_enable_n}
      == $past(byte_en_n[3:2]))
    else $error("x16 lane masks wrong");
  x16_col_a: assert property (
    (plain_req && array_x16 && cmd_req == SDCI_CMD_WRITE)
      |=> sdram_addr_out[9:0] == $past(addr_in[10:1]))
    else $error("x16 column routing wrong");
  bank32_16m_a: assert property (
    (plain_req && !array_x16 && !part_64m && cmd_req == SDCI_CMD_ACT)
      |=> sdram_bank_out == {1'b0, $past(addr_in[21])})
    else $error("x32 16M bank wrong");
  bank32_64m_a: assert property (
    (plain_req && !array_x16 && part_64m && cmd_req == SDCI_CMD_ACT)
      |=> sdram_bank_out == $past(addr_in[23:22])
      && sdram_addr_out[11] == $past(addr_in[13]))
    else $error("x32 64M bank wrong");
  bank16_16m_a: assert property (
    (plain_req && array_x16 && !part_64m && cmd_req == SDCI_CMD_ACT)
      |=> sdram_bank_out == {1'b0, $past(addr_in[20])})
    else $error("x16 16M bank wrong");
  bank16_64m_a: assert property (
    (plain_req && array_x16 && part_64m && cmd_req == SDCI_CMD_ACT)
      |=> sdram_bank_out == $past(addr_in[22:21])
      && sdram_addr_out[11] == $past(addr_in[12]))
    else $error("x16 64M bank wrong");

endmodule : sdci_cmd_pins

// *** tb/sdci_sdram_model.sv ***
`timescale 1ns/1ns
module sdci_sdram_model (
  // Pins from the controller
  input  wire logic        clk_sys,
  input  wire logic        cs_n,
  input  wire logic [2:0]  strobe_n,
  input  wire logic        ap,
  input  wire logic [11:0] addr,
  input  wire logic        cke,
  // Observed state
  output logic [11:0]      mode_reg,
  output logic             cke_fault
);
  initial begin
    mode_reg  = 12'h000;
    cke_fault = 1'b0;
  end
  // Only a selected load mode command is taken, on the rising edge
  always @(posedge clk_sys) begin
    if (cke !== 1'b1)
      cke_fault <= 1'b1;
    if (cs_n === 1'b0 && strobe_n === 3'h0 && ap === 1'b0)
      mode_reg <= addr;
  end
endmodule : sdci_sdram_model

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  import sdci_pkg::*;
  logic        clk_sys, rst_n, cs_valid, array_x16, part_64m, busy;
  logic [1:0]  port_size, cas_latency_field, sd_bank, exp_bank;
  sdci_cmd_t   cmd_req;
  logic [23:0] addr_in;
  logic [3:0]  byte_en_n, exp_code, exp_lanes;
  logic        cs_n, row_n, col_n, we_n, ap, cke, l3, l2, l1, l0;
  logic [11:0] sd_addr, exp_addr, mode_reg, last_op;
  logic        cke_fault, exp_ap, chk_ap, chk_addr, chk_bank, chk_lanes;
  logic        m64, pend, cs_prev;
  logic [31:0] seed;
  int          mismatches, cmp_count, cycles;

  sdci_cmd_pins u_sdci_cmd_pins (.clk_sys(clk_sys), .rst_n(rst_n),
    .cs_valid(cs_valid), .array_x16(array_x16), .part_64m(part_64m),
    .port_size(port_size), .cas_latency_field(cas_latency_field),
    .cmd_req(cmd_req), .addr_in(addr_in), .byte_en_n(byte_en_n),
    .mode_load_busy(busy), .chip_select_out_n(cs_n),
    .row_strobe_out_n(row_n), .column_strobe_out_n(col_n),
    .write_strobe_out_n(we_n), .precharge_flag_out_n(ap),
    .sdram_addr_out(sd_addr), .sdram_bank_out(sd_bank),
    .byte_lane3_enable_n(l3), .byte_lane2_enable_n(l2),
    .byte_lane1_enable_n(l1), .byte_lane0_enable_n(l0),
    .sdram_cke_out(cke));

  sdci_sdram_model u_sdci_sdram_model (.clk_sys(clk_sys), .cs_n(cs_n),
    .strobe_n({row_n, col_n, we_n}), .ap(ap), .addr(sd_addr), .cke(cke),
    .mode_reg(mode_reg), .cke_fault(cke_fault));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  function automatic logic [3:0] code_of(input sdci_cmd_t c);
    case (c)
      SDCI_CMD_NOP:   return SDCI_CODE_NOP;
      SDCI_CMD_ACT:   return SDCI_CODE_ACT;
      SDCI_CMD_READ:  return SDCI_CODE_READ;
      SDCI_CMD_WRITE: return SDCI_CODE_WRITE;
      SDCI_CMD_BTERM: return SDCI_CODE_BTERM;
      SDCI_CMD_PRE:   return SDCI_CODE_PRE;
      SDCI_CMD_REF:   return SDCI_CODE_REF;
      SDCI_CMD_LMODE: return SDCI_CODE_LMODE;
      default:        return SDCI_CODE_INH;
    endcase
  endfunction : code_of

  task automatic check(input string n, input logic [11:0] s,
                       input logic [11:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------
  // Scoreboard: check last edge, then predict the next one
  // ---------------------------------------------------------------
  always @(negedge clk_sys) begin
    logic      p, b;
    sdci_cmd_t ec;
    check("strobes", {8'h00, cs_n, row_n, col_n, we_n},
          {8'h00, exp_code});
    check("cke", {11'h000, cke}, 12'h001);
    if (chk_ap)
      check("ap", {11'h000, ap}, {11'h000, exp_ap});
    if (chk_addr)
      check("addr", sd_addr & {m64, 11'h7FF}, exp_addr);
    if (chk_bank)
      check("bank", {10'h000, sd_bank & {m64, 1'b1}},
            {10'h000, exp_bank});
    if (chk_lanes)
      check("lanes", {8'h00, l3, l2, l1, l0},
            {8'h00, exp_lanes});
    p = rst_n && cs_valid && (pend || !cs_prev);
    b = p && cmd_req != SDCI_CMD_NONE;
    check("busy", {11'h000, busy}, {11'h000, b});
    ec = b ? SDCI_CMD_LMODE : cmd_req;
    if (!(rst_n && cs_valid)) ec = SDCI_CMD_NONE;
    exp_code  = code_of(ec);
    chk_ap    = ec inside {SDCI_CMD_ACT, SDCI_CMD_READ, SDCI_CMD_WRITE,
                           SDCI_CMD_PRE, SDCI_CMD_LMODE};
    exp_ap    = ec == SDCI_CMD_PRE;
    if (ec == SDCI_CMD_ACT)
      exp_ap = port_size == 2'h0 ? addr_in[20] :
               port_size == 2'h1 ? addr_in[19] : addr_in[18];
    chk_bank  = ec inside {SDCI_CMD_ACT, SDCI_CMD_READ, SDCI_CMD_WRITE};
    chk_addr  = chk_bank || ec == SDCI_CMD_LMODE;
    chk_lanes = ec inside {SDCI_CMD_READ, SDCI_CMD_WRITE};
    m64       = part_64m || ec == SDCI_CMD_LMODE;
    exp_addr  = array_x16 ? {addr_in[12] & part_64m, 1'b0, addr_in[10:1]}
                          : {addr_in[13] & part_64m, 1'b0, addr_in[11:2]};
    exp_bank  = array_x16 ? (part_64m ? addr_in[22:21] : {1'b0, addr_in[20]})
                          : (part_64m ? addr_in[23:22] : {1'b0, addr_in[21]});
    exp_lanes = array_x16 ? {byte_en_n[3:2], 2'h3} : byte_en_n;
    if (ec == SDCI_CMD_LMODE) begin
      exp_addr = {3'h1, 2'h0, 3'({1'b0, cas_latency_field} + 3'h1),
                  1'b0, 3'h7};
      last_op  = exp_addr;
    end
    pend    = p && !b;
    cs_prev = rst_n && cs_valid;
  end

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Bounded run: random phase needs 3000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    seed = 32'hF647DEB4;
    {mismatches, cmp_count, cycles} = '0;
    {rst_n, cs_valid, array_x16, part_64m, pend, cs_prev} = '0;
    {chk_ap, chk_addr, chk_bank, chk_lanes, m64, exp_ap} = '0;
    {port_size, cas_latency_field, addr_in} = '0;
    cmd_req   = SDCI_CMD_NONE;
    byte_en_n = 4'hF;
    exp_code  = SDCI_CODE_INH;
    last_op   = 12'h000;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Mode load takes the first request, then every command in turn
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      seed = xs(seed);
      cs_valid  <= 1'b1;
      cmd_req   <= sdci_cmd_t'(i < 3 ? 4'h2 : 4'(i - 3));
      port_size <= 2'(i);
      addr_in   <= seed[23:0];
    end
    repeat (3000) begin
      @(posedge clk_sys);
      seed = xs(seed);
      cs_valid          <= seed[31:28] != 4'h0;
      cmd_req           <= sdci_cmd_t'(seed[3:0] % 4'h9);
      array_x16         <= seed[4];
      part_64m          <= seed[5];
      port_size         <= seed[7:6];
      cas_latency_field <= seed[9:8];
      byte_en_n         <= seed[13:10];
      seed = xs(seed);
      addr_in           <= seed[23:0];
    end
    @(posedge clk_sys);
    cs_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check("mode", mode_reg, last_op);
    check("cke_fault", {11'h000, cke_fault}, 12'h000);
    print_verdict();
  end
endmodule : testbench
